/* rtl/sbc_pkg.sv */
// Shared constants and carrier types for the storage boundary check block.
package sbc_pkg;
    localparam int ADDR_W          = 20;
    localparam int DATA_W          = 32;
    localparam int CHK_W           = 7;
    localparam int CODE_W          = DATA_W + CHK_W;
    localparam logic [19:0] UCODE_MIN_BYTES = 20'h08000;
    localparam logic [19:0] UCODE_MAX_BYTES = 20'h10000;
    localparam logic [19:0] UCODE_STEP_MASK = 20'h007ff;
    localparam logic [19:0] FRAME_BASE      = 20'h48000;
    localparam logic [19:0] BOUNDARY_RESET  = 20'h00000;
    localparam int MEM_WORDS       = 16384;
    localparam int CLK_PERIOD_PS   = 10000;
    localparam int FETCH_TIME_PS   = 540000;
    localparam int STORE_TIME_PS   = 607500;
    localparam int FETCH_CYCLES    =
        (FETCH_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STORE_CYCLES    =
        (STORE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic [1:0] {
        SBC_SRC_INSTR = 2'h0,
        SBC_SRC_OPND  = 2'h1,
        SBC_SRC_MICRO = 2'h2
    } sbc_src_t;

    typedef struct packed {
        sbc_src_t                  src;
        logic                      write;
        logic [ADDR_W-1:0]         addr;
        logic [DATA_W-1:0]         wdata;
    } sbc_req_t;

    typedef struct packed {
        logic                      addr_check;
        logic                      machine_check;
        logic                      corrected;
        logic                      uncorrectable;
        logic [DATA_W-1:0]         rdata;
    } sbc_rsp_t;
endpackage

/* rtl/sbc_ecc.sv */
// Single-error-correct, double-error-detect code for one storage word.
`timescale 1ns/1ns
module sbc_ecc (
    input  wire logic [sbc_pkg::DATA_W-1:0] wdata,
    input  wire logic [sbc_pkg::CODE_W-1:0] rcode,
    output logic      [sbc_pkg::CODE_W-1:0] wcode,
    output logic      [sbc_pkg::DATA_W-1:0] rdata,
    output logic                            corrected,
    output logic                            uncorrectable
);
    // Hamming position of data bit i (positions skip powers of two).
    function automatic logic [5:0] dpos(input int i);
        int p;
        int k;
        p = 0;
        k = -1;
        for (int n = 1; n < 40; n++) begin
            if ((n & (n - 1)) != 0) begin
                k++;
                if (k == i) begin
                    p = n;
                end
            end
        end
        return 6'(p);
    endfunction

    function automatic logic [5:0] syn_of(input logic [31:0] d);
        logic [5:0] s;
        s = 6'h00;
        for (int i = 0; i < 32; i++) begin
            if (d[i]) begin
                s = s ^ dpos(i);
            end
        end
        return s;
    endfunction

    logic [5:0] syn;
    logic       par;

    always_comb begin
        wcode = {^{syn_of(wdata), wdata}, syn_of(wdata), wdata};
    end

    always_comb begin
        syn = syn_of(rcode[31:0]) ^ rcode[37:32];
        par = ^rcode;
        rdata = rcode[31:0];
        corrected = 1'b0;
        uncorrectable = 1'b0;
        if (syn != 6'h00 && par) begin
            corrected = 1'b1;
            for (int i = 0; i < 32; i++) begin
                if (dpos(i) == syn) begin
                    rdata[i] = ~rcode[i];
                end
            end
        end else if (syn == 6'h00 && par) begin
            corrected = 1'b1;
        end else if (syn != 6'h00) begin
            uncorrectable = 1'b1;
        end
    end
endmodule

/* rtl/sbc_top.sv */
// Shared storage array with processor/microcode boundary checking.
`timescale 1ns/1ns
module sbc_top (
    input  wire logic                          sys_clk,
    input  wire logic                          rstn,
    input  wire logic [19:0]                   installed_bytes,
    input  wire logic                          microprogram_initial_load,
    input  wire logic                          bnd_wr,
    input  wire logic [19:0]                   bnd_wdata,
    input  wire logic                          req_valid,
    input  wire sbc_pkg::sbc_req_t             req,
    output logic                               req_ready,
    output logic                               rsp_valid,
    output sbc_pkg::sbc_rsp_t                  rsp,
    output logic                               bnd_valid,
    output logic                               bnd_refused,
    output logic                               ucode_run_enable,
    output logic [19:0]                        boundary
);
    typedef enum logic [1:0] {
        SBC_IDLE  = 2'h0,
        SBC_BUSY  = 2'h1,
        SBC_DONE  = 2'h2
    } sbc_state_t;

    // Physical word index for a logical address; frame storage above the
    // in-cabinet limit answers from processor address zero.
    // frame address remap
    function automatic logic [13:0] phys_word(input logic [19:0] a,
                                              input logic [19:0] top);
        logic [19:0] p;
        p = a;
        if (top > sbc_pkg::FRAME_BASE) begin
            if (a < top - sbc_pkg::FRAME_BASE) begin
                p = a + sbc_pkg::FRAME_BASE;
            end else if (a < top) begin
                p = a - (top - sbc_pkg::FRAME_BASE);
            end
        end
        return p[15:2];
    endfunction

    // Boundary legal: 2K aligned, region between 32K and 64K, inside storage.
    // A value above the top wraps the size huge, and one at the top gives size zero; both are refused.
    function automatic logic bnd_ok(input logic [19:0] b,
                                    input logic [19:0] top);
        logic [19:0] sz;
        sz = top - b;
        return ((b & sbc_pkg::UCODE_STEP_MASK) == 20'h00000) && (b < top) &&
               (sz >= sbc_pkg::UCODE_MIN_BYTES) &&
               (sz <= sbc_pkg::UCODE_MAX_BYTES);
    endfunction

    // One array holds both regions, including channel unit control words.
    // Contents are not reset, so a word read before its first store may
    // report a check-bit error.
    // microcode and control words
    logic [sbc_pkg::CODE_W-1:0] mem [sbc_pkg::MEM_WORDS];

    sbc_state_t        state;
    logic [6:0]        cnt;
    sbc_pkg::sbc_req_t cur;
    logic [13:0]       widx;
    logic [sbc_pkg::CODE_W-1:0] wcode;
    logic [sbc_pkg::CODE_W-1:0] rcode;
    logic [31:0]       rdata_fix;
    logic              ecc_cor;
    logic              ecc_unc;
    logic              is_micro;
    logic              below;
    logic              viol;
    logic              prog_viol;
    logic              micro_viol;
    logic              range_viol;

    // The code word is built from the held request, not the live bus.
    sbc_ecc u_ecc (
        .wdata         (cur.wdata),
        .rcode         (rcode),
        .wcode         (wcode),
        .rdata         (rdata_fix),
        .corrected     (ecc_cor),
        .uncorrectable (ecc_unc)
    );

    always_comb begin
        is_micro = (cur.src == sbc_pkg::SBC_SRC_MICRO);
        below = (cur.addr < boundary);
        prog_viol = ~is_micro & ~below;
        micro_viol = is_micro & below;
        range_viol = ~bnd_valid | (cur.addr >= installed_bytes);
        viol = prog_viol | micro_viol | range_viol;
        widx = phys_word(cur.addr, installed_bytes);
    end

    // A refused write leaves the old boundary and its valid flag in force.
    // boundary from load image
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            boundary <= sbc_pkg::BOUNDARY_RESET;
            bnd_valid <= 1'b0;
            bnd_refused <= 1'b0;
        end else begin
            bnd_refused <= 1'b0;
            if (bnd_wr) begin
                if (microprogram_initial_load &&
                    bnd_ok(bnd_wdata, installed_bytes)) begin
                    boundary <= bnd_wdata;
                    bnd_valid <= 1'b1;
                end else begin
                    bnd_refused <= 1'b1;
                end
            end
        end
    end

    // Run stays off during a load so half-loaded microcode never starts.
    // gate microcode execution
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ucode_run_enable <= 1'b0;
        end else begin
            ucode_run_enable <= bnd_valid & ~microprogram_initial_load;
        end
    end

    // An access spends all but the last cycle of its fixed time in BUSY; DONE commits a store and
    // launches the answer, so rsp_valid rises one storage cycle after the
    // take edge.
    // fixed fetch and store times
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state <= SBC_IDLE;
            cnt <= 7'h00;
            cur <= '0;
            req_ready <= 1'b0;
        end else begin
            case (state)
                SBC_IDLE: begin
                    req_ready <= 1'b1;
                    if (req_valid && req_ready) begin
                        cur <= req;
                        req_ready <= 1'b0;
                        cnt <= req.write ?
                            7'(sbc_pkg::STORE_CYCLES - 1) :
                            7'(sbc_pkg::FETCH_CYCLES - 1);
                        state <= SBC_BUSY;
                    end
                end
                SBC_BUSY: begin
                    if (cnt == 7'h01) begin
                        state <= SBC_DONE;
                    end
                    cnt <= cnt - 7'h01;
                end
                SBC_DONE: begin
                    state <= SBC_IDLE;
                    req_ready <= 1'b1;
                end
                default: begin
                    state <= SBC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (state == SBC_DONE && cur.write && !viol) begin
            mem[widx] <= wcode;
        end
    end

    // The array is read every cycle, so the word has settled long before
    // DONE hands it to the error logic.
    always_ff @(posedge sys_clk) begin
        rcode <= mem[phys_word(cur.addr, installed_bytes)];
    end

    // A violating access returns no data and no corrected or uncorrectable flag, so nothing of
    // the other region leaks out through the answer.
    // corrected read data
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rsp_valid <= 1'b0;
            rsp <= '0;
        end else begin
            rsp_valid <= (state == SBC_DONE);
            if (state == SBC_DONE) begin
                rsp.addr_check <= viol & ~is_micro;
                rsp.machine_check <= viol & is_micro;
                rsp.corrected <= ~viol & ~cur.write & ecc_cor;
                rsp.uncorrectable <= ~viol & ~cur.write & ecc_unc;
                rsp.rdata <= (viol | cur.write) ? 32'h00000000 : rdata_fix;
            end
        end
    end
endmodule

/* sim/sbc_top_checker.sv */
// Concurrent assertions on the ports of the storage boundary check block.
`timescale 1ns/1ns
module sbc_top_checker (
    input wire logic              sys_clk,
    input wire logic              rstn,
    input wire logic [19:0]       installed_bytes,
    input wire logic              microprogram_initial_load,
    input wire logic              bnd_wr,
    input wire logic [19:0]       bnd_wdata,
    input wire logic              req_valid,
    input wire sbc_pkg::sbc_req_t req,
    input wire logic              req_ready,
    input wire logic              rsp_valid,
    input wire sbc_pkg::sbc_rsp_t rsp,
    input wire logic              bnd_valid,
    input wire logic              bnd_refused,
    input wire logic              ucode_run_enable,
    input wire logic [19:0]       boundary
);
    logic              take;
    logic              held_micro;
    logic [19:0]       held_addr;
    logic [19:0]       ucode_size;
    assign take = req_valid && req_ready;
    assign ucode_size = installed_bytes - bnd_wdata;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // The request leaves the bus long before its answer, so keep its cause.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            held_micro <= 1'b0;
            held_addr  <= 20'h00000;
        end else if (take) begin
            held_micro <= req.src == sbc_pkg::SBC_SRC_MICRO;
            held_addr  <= req.addr;
        end
    end
    chk_prog_past_bound: assert property (
        rsp_valid && bnd_valid && !held_micro && held_addr >= boundary
        |-> rsp.addr_check && rsp.rdata == 32'h0)
        else $error("program access at or above boundary not flagged");
    chk_micro_below_bound: assert property (
        rsp_valid && bnd_valid && held_micro && held_addr < boundary
        |-> rsp.machine_check)
        else $error("microprogram access below boundary not flagged");
    chk_region_side_ok: assert property (
        rsp_valid && bnd_valid && held_addr < installed_bytes
        && (held_micro == (held_addr >= boundary))
        |-> !rsp.addr_check && !rsp.machine_check)
        else $error("access on its own side of boundary flagged");
    chk_fetch_time: assert property (
        take && !req.write |-> ##55 rsp_valid)
        else $error("fetch answer not at 55 cycles");
    chk_store_time: assert property (
        take && req.write |-> ##62 rsp_valid)
        else $error("store answer not at 62 cycles");
    chk_write_outside_load: assert property (
        bnd_wr && !microprogram_initial_load
        |=> bnd_refused && boundary == $past(boundary))
        else $error("boundary write outside load not refused");
    chk_bad_step_size: assert property (
        bnd_wr && ((bnd_wdata & sbc_pkg::UCODE_STEP_MASK) != 20'h0
        || ucode_size > sbc_pkg::UCODE_MAX_BYTES) |=> bnd_refused)
        else $error("unaligned or oversized boundary accepted");
    chk_legal_bound_load: assert property (
        bnd_wr && microprogram_initial_load
        && (bnd_wdata & sbc_pkg::UCODE_STEP_MASK) == 20'h0
        && ucode_size >= sbc_pkg::UCODE_MIN_BYTES
        && ucode_size <= sbc_pkg::UCODE_MAX_BYTES
        |=> bnd_valid && !bnd_refused && boundary == $past(bnd_wdata))
        else $error("legal boundary write not taken");
    chk_run_after_bound: assert property (
        ucode_run_enable == ($past(bnd_valid)
        && !$past(microprogram_initial_load)))
        else $error("microcode run enable wrong");
    chk_min_ucode_size: assert property (
        bnd_valid |-> installed_bytes - boundary >= sbc_pkg::UCODE_MIN_BYTES)
        else $error("microcode region below minimum");
endmodule
bind sbc_top sbc_top_checker u_chk (.sys_clk, .rstn, .installed_bytes,
    .microprogram_initial_load, .bnd_wr, .bnd_wdata, .req_valid, .req,
    .req_ready, .rsp_valid, .rsp, .bnd_valid, .bnd_refused,
    .ucode_run_enable, .boundary);

/* sim/sbc_cpu_model.sv */
// Behavioural CPU sequencer that issues one storage access at a time.
`timescale 1ns/1ns
module sbc_cpu_model (
    input  wire logic               sys_clk,
    input  wire logic               req_ready,
    input  wire logic               rsp_valid,
    input  wire sbc_pkg::sbc_rsp_t  rsp,
    output sbc_pkg::sbc_req_t       req,
    output logic                    req_valid
);
    initial begin
        req_valid = 1'b0;
        req       = '0;
    end
    // The released bus is inverted so any later use of the stale request shows up as a wrong answer.
    task automatic access(input sbc_pkg::sbc_req_t r,
                          output sbc_pkg::sbc_rsp_t o, output int lat);
        int n;
        n = 0;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req       <= r;
        do begin
            @(posedge sys_clk);
            n = n + 1;
        end while (!req_ready && n < 100);
        req_valid <= 1'b0;
        req       <= ~r;
        // Latency counts edges from the take edge to the answer edge.
        n = 0;
        do begin
            @(posedge sys_clk);
            n = n + 1;
        end while (!rsp_valid && n < 200);
        o   = rsp;
        lat = n;
    endtask
endmodule

/* sim/test_storage_boundary_check.sv */
// Self-checking testbench for the storage boundary check block.
`timescale 1ns/1ns
module test_storage_boundary_check;
    logic              sys_clk;
    logic              rstn;
    logic [19:0]       installed_bytes;
    logic              microprogram_initial_load;
    logic              bnd_wr;
    logic [19:0]       bnd_wdata;
    logic              req_valid;
    sbc_pkg::sbc_req_t req;
    logic              req_ready;
    logic              rsp_valid;
    sbc_pkg::sbc_rsp_t rsp;
    logic              bnd_valid;
    logic              bnd_refused;
    logic              ucode_run_enable;
    logic [19:0]       boundary;
    int                mismatches;
    int                compares;
    sbc_top dut (.sys_clk, .rstn, .installed_bytes,
        .microprogram_initial_load, .bnd_wr, .bnd_wdata, .req_valid, .req,
        .req_ready, .rsp_valid, .rsp, .bnd_valid, .bnd_refused,
        .ucode_run_enable, .boundary);
    sbc_cpu_model cpu (.sys_clk, .req_ready, .rsp_valid, .rsp, .req,
        .req_valid);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic bnd_write(input logic [19:0] v, input logic ld,
                             input logic ok, input logic [19:0] exp_b);
        @(posedge sys_clk);
        microprogram_initial_load <= ld;
        bnd_wr                    <= 1'b1;
        bnd_wdata                 <= v;
        @(posedge sys_clk);
        bnd_wr <= 1'b0;
        @(negedge sys_clk);
        check(32'(bnd_refused), 32'(!ok));
        check(32'(boundary), 32'(exp_b));
    endtask
    task automatic t_boundary_load();
        check(32'(ucode_run_enable), 32'h0);
        acc(sbc_pkg::SBC_SRC_MICRO, 0, 20'h2fffc, 0, 0, 1, 0);
        bnd_write(20'h28000, 1'b0, 1'b0, 20'h00000);
        bnd_write(20'h28400, 1'b1, 1'b0, 20'h00000);
        bnd_write(20'h1f800, 1'b1, 1'b0, 20'h00000);
        bnd_write(20'h28800, 1'b1, 1'b0, 20'h00000);
        bnd_write(20'h20000, 1'b1, 1'b1, 20'h20000);
        bnd_write(20'h28000, 1'b1, 1'b1, 20'h28000);
        repeat (2) @(negedge sys_clk);
        check(32'(ucode_run_enable), 32'h0);
        @(posedge sys_clk);
        microprogram_initial_load <= 1'b0;
        repeat (3) @(negedge sys_clk);
        check(32'(ucode_run_enable), 32'h1);
        bnd_write(20'h20000, 1'b0, 1'b0, 20'h28000);
    endtask
    task automatic acc(input sbc_pkg::sbc_src_t s, input int w,
                       input logic [19:0] a, input logic [31:0] d,
                       input int ac, input int mc, input logic [31:0] rd);
        sbc_pkg::sbc_rsp_t o;
        int                lat;
        int                exp_lat;
        exp_lat = (w != 0) ? sbc_pkg::STORE_CYCLES + 1
                           : sbc_pkg::FETCH_CYCLES + 1;
        cpu.access('{src: s, write: w[0], addr: a, wdata: d}, o, lat);
        check(32'(o.addr_check), 32'(ac));
        check(32'(o.machine_check), 32'(mc));
        check(32'({o.corrected, o.uncorrectable}), 32'h0);
        if (w == 0) check(o.rdata, rd);
        check(lat, exp_lat);
    endtask
    task automatic t_access();
        acc(sbc_pkg::SBC_SRC_INSTR, 1, 20'h00100, 32'h5a5ac3c3, 0, 0, 0);
        acc(sbc_pkg::SBC_SRC_MICRO, 1, 20'h00100, 32'h12345678, 0, 1, 0);
        acc(sbc_pkg::SBC_SRC_OPND, 0, 20'h00100, 0, 0, 0, 32'h5a5ac3c3);
        acc(sbc_pkg::SBC_SRC_INSTR, 0, 20'h28000, 0, 1, 0, 0);
        acc(sbc_pkg::SBC_SRC_MICRO, 1, 20'h2fffc, 32'hdeadbeef, 0, 0, 0);
        acc(sbc_pkg::SBC_SRC_OPND, 1, 20'h2fffc, 32'h0, 1, 0, 0);
        acc(sbc_pkg::SBC_SRC_MICRO, 0, 20'h2fffc, 0, 0, 0, 32'hdeadbeef);
        acc(sbc_pkg::SBC_SRC_MICRO, 0, 20'h27ffc, 0, 0, 1, 0);
        acc(sbc_pkg::SBC_SRC_MICRO, 0, 20'h30000, 0, 0, 1, 0);
    endtask
    task automatic t_frame_remap();
        @(posedge sys_clk);
        installed_bytes <= 20'h50000;
        bnd_write(20'h48000, 1'b1, 1'b1, 20'h48000);
        acc(sbc_pkg::SBC_SRC_OPND, 0, 20'h08100, 0, 0, 0, 32'h5a5ac3c3);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        mismatches = 0;
        compares = 0;
        rstn = 1'b0;
        installed_bytes = 20'h30000;
        microprogram_initial_load = 1'b0;
        bnd_wr = 1'b0;
        bnd_wdata = 20'h00000;
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_boundary_load();
        t_access();
        t_frame_remap();
        tally_and_finish();
    end
    // About 700 cycles of work are expected; allow several times that.
    initial begin
        #40000;
        mismatches++;
        tally_and_finish();
    end
endmodule
